// >>> common/timer0_mode_regs.vh
// Constants for the Timer0 mode register, prescaler and clock selection
// Function
// RQ1 - Mode register reached only by dedicated instructions
// RQ2 - Timer0 prescale: code 000 is 1:2, 111 is 1:256
// RQ3 - Watchdog reset mode: 000 is 1:1, 111 1:128
// RQ4 - Watchdog interrupt mode ratios match the Timer0 column
// RQ5 - Assignment bit set routes prescaler to watchdog
// RQ6 - Firmware programs prescaler before enabling watchdog/interrupt
// RQ7 - Edge bit 1 counts falling, 0 counts rising
// RQ8 - Edge bit applies to low-oscillator source too
// RQ9 - Source bit 0 instruction clock, else pin
// RQ10 - Source and low-clock bits set select low oscillator
// RQ11 - Count value read returns present prescaler count
// RQ12 - Prescaler clocks only its assigned party
`ifndef TIMER0_MODE_REGS_VH
`define TIMER0_MODE_REGS_VH

// ==========================================================
// Mode register layout
`define MODE_RESET 8'h3F
`define MODE_LOW_OSC_BIT 7
`define MODE_SPARE_BIT 6
`define MODE_SOURCE_BIT 5
`define MODE_EDGE_BIT 4
`define MODE_WDT_BIT 3
`define MODE_RATIO_HI 2
`define MODE_RATIO_LO 0

// ==========================================================
// Prescaler counter
`define PRESCALE_RESET 8'hFF
`define PRESCALE_ZERO 8'h00
`define PRESCALE_ONE 8'h01

`endif

// >>> hdl/prescale_tap.v
// Prescaler ratio decoder producing the division tap mask
`timescale 1ns/1ns
`include "timer0_mode_regs.vh"

module prescale_tap (
  // Mode inputs
  input wire [2:0] ratio_sel,
  input wire to_watchdog,
  input wire wdt_reset_mode,
  // Mask of low counter bits that must all be zero for a tick
  output wire [7:0] tap_mask
);

  // Watchdog reset mode uses one stage less
  wire reset_col;
  assign reset_col = to_watchdog & wdt_reset_mode; // [RQ3] [RQ4]

  // Ratio 2^(n+1) or 2^n: mask has n+1 or n low bits set
  wire [8:0] span;
  assign span = reset_col ? (9'h001 << ratio_sel) : // [RQ3]
                (9'h002 << ratio_sel); // [RQ2] [RQ4]

  wire [8:0] mask_full;
  assign mask_full = span - 9'h001;
  assign tap_mask = mask_full[7:0];

endmodule

// >>> hdl/timer0_prescaler_clock_select.v
// Timer0 mode register, shared prescaler and count source selection
`timescale 1ns/1ns
`include "timer0_mode_regs.vh"

module timer0_prescaler_clock_select (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Instruction interface
  input wire timer_mode_write_instr,
  input wire timer_mode_read_instr,
  input wire [7:0] instr_wdata,
  input wire count_value_read,
  // Configuration and count sources
  input wire wdt_reset_mode,
  input wire inst_clk_tick,
  input wire ext_count_clock_pin,
  input wire low_osc_clk,
  input wire wdt_tick,
  // Read data
  output reg [7:0] mode_rdata,
  output reg mode_rvalid,
  output reg [7:0] count_rdata,
  // Mode fields seen by the timer and watchdog
  output reg [2:0] prescale_ratio_sel,
  output reg prescale_to_watchdog,
  output reg count_edge_sel,
  output reg count_source_sel,
  output reg low_osc_source_sel,
  output reg spare_storage_bit,
  // Advance strobes and prescaler count value
  output reg timer0_inc,
  output reg wdt_inc,
  output reg [7:0] prescaler_count_value
);

  // ==========================================================
  // Overview
  // The mode register is only reached by the two dedicated
  // instructions; ordinary data-memory accesses never see it.
  // One prescaler is shared: it divides either the Timer0 count
  // source or the watchdog base tick, never both at once.
  // The party without the prescaler advances on every one of its
  // own ticks, undivided.
  // Field outputs lag the mode register by one cycle, since every
  // output comes straight from a flip-flop.
  // A mode write reloads the prescaler to all ones, so a new ratio
  // always starts from a clean count.
  // Hazard: changing the source selection could make the edge
  // detector compare levels of two different lines; the previous
  // level is therefore reloaded from the new line on a mode write.

  // ==========================================================
  // Helper functions

  // Level of the external source for a given low-clock select bit
  function pick_level;
    input low_sel;
    input osc_level;
    input pin_level;
    begin
      if (low_sel) begin
        pick_level = osc_level;
      end else begin
        pick_level = pin_level;
      end
    end
  endfunction

  // Edge decode shared by the pin and the low oscillator paths
  function edge_seen;
    input prev_level;
    input now_level;
    input falling;
    begin
      if (falling) begin
        edge_seen = prev_level & ~now_level;
      end else begin
        edge_seen = ~prev_level & now_level;
      end
    end
  endfunction

  // ==========================================================
  // Mode register
  reg [7:0] mode_reg;

  // Written only by the dedicated write instruction
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= `MODE_RESET;
    end else if (timer_mode_write_instr) begin
      mode_reg <= instr_wdata; // [RQ1]
    end
  end

  // Read data returned by the dedicated read instruction
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_rdata <= 8'h00;
      mode_rvalid <= 1'b0;
    end else begin
      mode_rvalid <= timer_mode_read_instr;
      if (timer_mode_read_instr) begin
        mode_rdata <= mode_reg; // [RQ1]
      end
    end
  end

  // Field outputs registered from the mode register
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale_ratio_sel <= 3'h7;
      prescale_to_watchdog <= 1'b1;
      count_edge_sel <= 1'b1;
      count_source_sel <= 1'b1;
      low_osc_source_sel <= 1'b0;
      spare_storage_bit <= 1'b0;
    end else begin
      prescale_ratio_sel <= mode_reg[`MODE_RATIO_HI:`MODE_RATIO_LO];
      prescale_to_watchdog <= mode_reg[`MODE_WDT_BIT];
      count_edge_sel <= mode_reg[`MODE_EDGE_BIT];
      count_source_sel <= mode_reg[`MODE_SOURCE_BIT];
      low_osc_source_sel <= mode_reg[`MODE_LOW_OSC_BIT];
      spare_storage_bit <= mode_reg[`MODE_SPARE_BIT];
    end
  end

  // ==========================================================
  // Count source selection and edge detection
  wire src_ext;
  wire src_level;
  reg src_prev_reg;
  wire src_edge;
  wire src_tick;

  assign src_ext = mode_reg[`MODE_SOURCE_BIT];
  // Low oscillator replaces the pin when both bits are set
  assign src_level = pick_level(mode_reg[`MODE_LOW_OSC_BIT],
                                low_osc_clk, // [RQ10]
                                ext_count_clock_pin); // [RQ9]

  // Previous level of the selected external source
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      src_prev_reg <= 1'b0;
    end else if (timer_mode_write_instr) begin
      // Follow the newly selected line so a switch is not an edge
      src_prev_reg <= pick_level(instr_wdata[`MODE_LOW_OSC_BIT],
                                 low_osc_clk, ext_count_clock_pin);
    end else begin
      src_prev_reg <= src_level;
    end
  end

  // Edge bit 1 picks falling, 0 picks rising, for pin or oscillator
  assign src_edge = edge_seen(src_prev_reg, src_level,
                              mode_reg[`MODE_EDGE_BIT]); // [RQ7] [RQ8]
  // Source bit 0 counts the instruction clock
  assign src_tick = src_ext ? src_edge : inst_clk_tick; // [RQ9]

  // ==========================================================
  // Shared prescaler
  wire to_wdt;
  wire pre_in;
  wire [7:0] tap_mask;
  wire pre_out;
  reg [7:0] pre_reg;
  reg [7:0] pre_next;

  assign to_wdt = mode_reg[`MODE_WDT_BIT];
  // Prescaler input comes from the party it serves
  assign pre_in = to_wdt ? wdt_tick : src_tick; // [RQ5]

  prescale_tap u_tap (
    .ratio_sel(mode_reg[`MODE_RATIO_HI:`MODE_RATIO_LO]),
    .to_watchdog(to_wdt),
    .wdt_reset_mode(wdt_reset_mode),
    .tap_mask(tap_mask)
  );

  // Counts down from all ones; tick when masked low bits are zero and wrap back to ones
  always @* begin
    pre_next = pre_reg;
    if (pre_in) begin
      pre_next = pre_reg - `PRESCALE_ONE;
    end
  end

  assign pre_out = pre_in &
                   ((pre_reg & tap_mask) == `PRESCALE_ZERO); // [RQ2] [RQ3]

  // Prescaler counter; cleared back to all ones on a mode write
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_reg <= `PRESCALE_RESET;
    end else if (timer_mode_write_instr) begin
      pre_reg <= `PRESCALE_RESET;
    end else begin
      pre_reg <= pre_next;
    end
  end

  // ==========================================================
  // Advance strobes and count value read
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer0_inc <= 1'b0;
      wdt_inc <= 1'b0;
      prescaler_count_value <= `PRESCALE_RESET;
      count_rdata <= `PRESCALE_RESET;
    end else begin
      // Undivided source edges go to Timer0 when prescaler is elsewhere
      timer0_inc <= to_wdt ? src_tick : pre_out; // [RQ12] [RQ5]
      wdt_inc <= to_wdt ? pre_out : wdt_tick; // [RQ12] [RQ5]
      prescaler_count_value <= pre_reg; // [RQ11]
      if (count_value_read) begin
        count_rdata <= pre_reg; // [RQ11]
      end
    end
  end

endmodule

// >>> dv/timer0_psc_sva.sv
// Checker for the Timer0 mode register and prescaler strobes
`timescale 1ns/1ns
module timer0_psc_sva (
  // Clock, reset and requests
  input wire clk, reset_n, timer_mode_write_instr, timer_mode_read_instr,
  input wire [7:0] instr_wdata,
  input wire inst_clk_tick, wdt_tick,
  // Observed outputs
  input wire [7:0] mode_rdata, prescaler_count_value,
  input wire mode_rvalid, timer0_inc, wdt_inc, prescale_to_watchdog,
  input wire [2:0] prescale_ratio_sel,
  input wire count_edge_sel, count_source_sel,
  input wire low_osc_source_sel, spare_storage_bit
);
  // Field outputs packed back in register order
  wire [7:0] fld = {low_osc_source_sel, spare_storage_bit, count_source_sel,
    count_edge_sel, prescale_to_watchdog, prescale_ratio_sel};
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ======
  // Mode register access
  property p_rv; timer_mode_read_instr |=> mode_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no rvalid");
  property p_rd; mode_rvalid |-> mode_rdata == fld; endproperty
  a_rd: assert property (p_rd) else $error("bad rdata");
  property p_wr; timer_mode_write_instr |-> ##2 fld == $past(instr_wdata, 2);
  endproperty
  a_wr: assert property (p_wr) else $error("bad fields");
  property p_cv;
    timer_mode_write_instr |-> ##2 prescaler_count_value == 8'hFF;
  endproperty
  a_cv: assert property (p_cv) else $error("no reload");
  // Strobes tied to their cause; fields lag the register by one cycle
  property p_un; prescale_to_watchdog && !count_source_sel && inst_clk_tick
    && !$past(timer_mode_write_instr) |=> timer0_inc; endproperty
  a_un: assert property (p_un) else $error("tick lost");
  property p_two; !prescale_to_watchdog && timer0_inc
    && !$past(timer_mode_write_instr) |=> !timer0_inc; endproperty
  a_two: assert property (p_two) else $error("undivided");
  property p_wd; wdt_inc |-> $past(wdt_tick); endproperty
  a_wd: assert property (p_wd) else $error("stray wdt_inc");
  property p_src; timer0_inc && !count_source_sel |-> $past(inst_clk_tick);
  endproperty
  a_src: assert property (p_src) else $error("stray inc");
  c_rd: cover property (mode_rvalid);
  c_un: cover property (prescale_to_watchdog && timer0_inc);
  c_ext: cover property (count_source_sel && timer0_inc);
endmodule

// >>> dv/timer0_prescaler_clock_select_tb.sv
// Self-checking bench for the Timer0 mode and prescaler block
`timescale 1ns/1ns
`include "timer0_mode_regs.vh"
`define CHK(n,e,s) begin check_count++; if ((s) !== (e)) begin \
  fail_count++; $display("Error %s exp %0h got %0h", n, e, s); end end
module timer0_prescaler_clock_select_tb;
  // Design ports, inputs idle at time zero
  logic clk = 0, reset_n = 0, timer_mode_write_instr = 0, wdt_tick = 0;
  logic timer_mode_read_instr = 0, count_value_read = 0, inst_clk_tick = 0;
  logic wdt_reset_mode = 0, ext_count_clock_pin = 0, low_osc_clk = 0;
  logic [7:0] instr_wdata = 0, mode_rdata, count_rdata, prescaler_count_value;
  logic [2:0] prescale_ratio_sel;
  logic mode_rvalid, prescale_to_watchdog, count_edge_sel, count_source_sel;
  logic low_osc_source_sel, spare_storage_bit, timer0_inc, wdt_inc;
  int fail_count = 0, check_count = 0, cyc = 0, nt = 0, nw = 0, r;
  logic [7:0] q[$], d, e;
  always #5 clk = ~clk;
  timer0_prescaler_clock_select dut (.*);
  // ======
  // Strobe counts, hang limit, read data against the oldest note
  always @(posedge clk) begin
    nt += timer0_inc;
    nw += wdt_inc;
    cyc++;
    if (cyc == 20000) begin fail_count++; conclude; end
    if (mode_rvalid === 1'b1) begin
      e = q.pop_front();
      `CHK("mode_rdata", e, mode_rdata)
    end
  end
  task automatic conclude;
    $display("Errors %0d, checks %0d", fail_count, check_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Instruction strobes last one cycle, then the fields settle
  task automatic wm(input logic [7:0] v);
    @(negedge clk) timer_mode_write_instr = 1;
    instr_wdata = v;
    @(negedge clk) timer_mode_write_instr = 0;
    repeat (3) @(negedge clk);
  endtask
  task automatic rm(input logic [7:0] v);
    q.push_back(v);
    @(negedge clk) timer_mode_read_instr = 1;
    @(negedge clk) timer_mode_read_instr = 0;
    repeat (3) @(negedge clk);
  endtask
  task automatic tk(input int n, input logic w);
    repeat (n) begin
      @(negedge clk) inst_clk_tick = 1;
      wdt_tick = w;
      @(negedge clk) inst_clk_tick = 0;
      wdt_tick = 0;
    end
    repeat (3) @(negedge clk);
  endtask
  task automatic lv(input logic p, input logic l);
    @(negedge clk) ext_count_clock_pin = p;
    low_osc_clk = l;
    repeat (3) @(negedge clk);
  endtask
  initial begin
    void'($urandom(57));
    repeat (3) @(negedge clk);
    reset_n = 1;
    rm(`MODE_RESET);
    repeat (4) begin
      d = 8'($urandom);
      wm(d);
      rm(d);
    end
    wm(8'h00);
    tk(3, 0);
    @(negedge clk) count_value_read = 1;
    @(negedge clk) count_value_read = 0;
    @(negedge clk);
    `CHK("count_rdata", `PRESCALE_RESET - 8'h03, count_rdata)
    // Every ratio code for Timer0, watchdog reset and interrupt
    for (int m = 0; m < 3; m++) for (int s = 0; s < 8; s++) begin
      wdt_reset_mode = (m == 1);
      wm({4'h0, m != 0, s[2:0]});
      r = (m == 1) ? 1 << s : 2 << s;
      nt = 0;
      nw = 0;
      tk(r, m != 0);
      `CHK("timer0_inc", m ? r : 1, nt)
      `CHK("wdt_inc", m ? 1 : 0, nw)
    end
    // Pin or low oscillator, each edge; the other line is wiggled
    for (int k = 0; k < 4; k++) begin
      wm({k[1], 2'b01, k[0], 4'h8});
      nt = 0;
      lv(k[1], !k[1]);
      lv(0, 0);
      lv(!k[1], k[1]);
      `CHK("rise", int'(!k[0]), nt)
      lv(0, 0);
      `CHK("fall", 1, nt)
    end
    conclude;
  end
endmodule
bind timer0_prescaler_clock_select timer0_psc_sva chk (.*);
